// ===== shared/dsac_params.svh
`ifndef DSAC_PARAMS_SVH
`define DSAC_PARAMS_SVH
// data map
`define DSAC_ADR_ALT     8'hFC
`define DSAC_ADR_STK     8'hFD
`define DSAC_ADR_PRIM    8'hFE
`define DSAC_ADR_SEG     8'hFF
`define DSAC_REG_HI      4'hF
`define DSAC_RAM_TOP     7'h6F
`define DSAC_GREG_TOP    4'hB
`define DSAC_SEG_BASE    8'h00
// reset and fixed values
`define DSAC_PC_RST      15'h0000
`define DSAC_STK_RST     8'h6F
`define DSAC_SEG_RST     8'h00
`define DSAC_PTR_RST     8'h00
`define DSAC_IRQ_VEC     15'h00FF
`define DSAC_UNPROG      8'h00
`define DSAC_UNDEF_RD    8'h00
// option word fields
`define DSAC_OPT_POR     6
`define DSAC_OPT_SEC     5
`define DSAC_OPT_CK_HI   4
`define DSAC_OPT_CK_LO   3
`define DSAC_OPT_SUPV    2
`define DSAC_OPT_PORTF   1
`define DSAC_OPT_HALT    0
`endif

// ===== shared/dsac_pkg.sv
package dsac_pkg;
    typedef enum logic [1:0] {
        DSAC_CK_EXT  = 2'h0,
        DSAC_CK_RC   = 2'h1,
        DSAC_CK_XTAL = 2'h2,
        DSAC_CK_XBR  = 2'h3
    } dsac_clk_src_t;
    typedef enum logic [2:0] {
        DSAC_RG_BASE,
        DSAC_RG_HOLE,
        DSAC_RG_GREG,
        DSAC_RG_PTR,
        DSAC_RG_PERIPH,
        DSAC_RG_EXT,
        DSAC_RG_NONE
    } dsac_region_t;
endpackage

// ===== hw/dsac_top.sv
`timescale 1ns/1ps
`include "dsac_params.svh"
// Functional notes
// - 15-bit counter, 7 high, 8 low bits
// - counter cleared to zero by reset
// - every interrupt vectors to location 0FF
// - unprogrammed program bytes read 00
// - pointers mapped at FC, FD, FE
// - segment register read/write at FF
// - address bit7 high uses base segment
// - bit7 low prepends segment byte
// - stack accesses always use segment 0
// - stack pointer resets to 06F
// - base RAM 0000-006F, 0070-007F empty
// - extra RAM in segments 1 to 3
// - mask-ROM variant lacks segments 2, 3
// - option bit6 enables power-on reset
// - option bit5 enables code security
// - option bits4:3 select clock source
// - option bit2 low enables supervisory timer
// - option bit1 high disables port F drive
// - option bit0 high disables halt mode
// - option word unreachable by instructions
// - reset tri-states ports, drives D high
// - reset clears control registers
// - warm reset keeps alt and primary pointers; timers only with R/C clock
module dsac_top
    import dsac_pkg::*;
#(
    parameter int EXT_SEGS = 3,     // extra 128-byte segments
    parameter bit MASK_ROM = 1'b0   // variant with one extra seg
) (
    input  wire logic        core_clk,       // core clock
    input  wire logic        arst_n,         // cold reset, low
    input  wire logic        clk_en,         // freezes state when low
    input  wire logic        reset_pin_n,    // reset pin, async
    input  wire logic        por_req,        // power-on detector
    input  wire logic [7:0]  opt_word,       // factory option word
    input  wire logic [7:0]  daddr,          // single-byte address
    input  wire logic        drd,            // data read strobe
    input  wire logic        dwr,            // data write strobe
    input  wire logic        dstk,           // access via stack ptr
    input  wire logic [7:0]  dwdata,         // write data
    output logic      [7:0]  drdata,         // read data
    output logic      [15:0] deff_addr,      // formed address
    output logic             periph_sel,     // peripheral access
    input  wire logic [7:0]  periph_rdata,   // peripheral data
    input  wire logic        pc_load,        // load program counter
    input  wire logic [14:0] pc_load_val,    // value to load
    input  wire logic        pc_inc,         // advance counter
    input  wire logic        irq_take,       // interrupt taken
    output logic      [6:0]  prog_count_high, // counter high part
    output logic      [7:0]  prog_count_low,  // counter low byte
    input  wire logic [7:0]  pmem_raw,       // program array data
    input  wire logic        pmem_prog,      // location programmed
    output logic      [7:0]  pmem_rdata,     // program fetch data
    output logic      [7:0]  alt_ptr,        // alternate pointer
    output logic      [7:0]  call_frame_top, // stack pointer
    output logic      [7:0]  prim_ptr,       // primary pointer
    output logic      [7:0]  window_bank,    // segment register
    output logic             por_en,         // power-on reset on
    output logic             secure_en,      // code security on
    output dsac_clk_src_t    clk_src,        // clock source
    output logic             clock_drive_out, // G7 drives crystal
    output logic             supv_en,        // supervisory timer on
    output logic             g1_supv_pin,    // G1 is timer output
    output logic             portf_drv_en,   // port F bidirectional
    output logic             halt_allowed,   // halt permitted
    output logic             in_reset,       // warm reset active
    output logic             ports_hiz,      // ports L,C,G,F hi-z
    output logic             port_d_high,    // port D forced high
    output logic             ctl_clear,      // clear control regs
    output logic             keep_acc_tmr    // keep acc and timers
);

// ----------------------------------------------------------------
// reset release and pin filter
// ----------------------------------------------------------------
localparam int EIW = $clog2(EXT_SEGS * 128);
// the mask-ROM variant keeps only the first extra segment; reads of
// the others fall through to the fixed empty value
localparam int NSEG = MASK_ROM ? 1 : EXT_SEGS;

logic [1:0] rsync_q;
logic       rst_n;
logic [2:0] pin_q;
logic       pin_lvl_q;
logic       warm_q;
logic       opt_vld_q;
logic [7:0] opt_q;
logic       warm;

// the copy releases on a clock edge, so no flop leaves reset inside
// its setup window; it ignores clk_en so a frozen core still leaves
// reset
always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        rsync_q <= 2'h0;
    end else begin
        rsync_q <= {rsync_q[0], 1'b1};
    end
end
assign rst_n = rsync_q[1];

// the filter starts at the reset level, so a cold start always
// passes through one warm reset before the core runs
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        pin_q     <= 3'h0;
        pin_lvl_q <= 1'b0;
    end else if (clk_en) begin
        pin_q <= {pin_q[1:0], reset_pin_n};
        if (pin_q[1] == pin_q[2]) begin
            pin_lvl_q <= pin_q[2];
        end
    end
end

// power-on detector only counts when the option enables it
assign warm = !pin_lvl_q || (por_en && por_req);

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        warm_q <= 1'b1;
    end else if (clk_en) begin
        warm_q <= warm;
    end
end

// ----------------------------------------------------------------
// option word capture and decode
// ----------------------------------------------------------------
// strap taken by a clocked process after release; it has no data
// address, so no instruction can reach it
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        opt_vld_q <= 1'b0;
        opt_q     <= 8'h00;
    end else if (clk_en && !opt_vld_q) begin
        opt_vld_q <= 1'b1;
        opt_q     <= opt_word;
    end
end

// bit 7 is a don't-care and is never looked at
assign por_en          = opt_q[`DSAC_OPT_POR];
assign secure_en       = opt_q[`DSAC_OPT_SEC];
assign clk_src         = dsac_clk_src_t'(
    opt_q[`DSAC_OPT_CK_HI:`DSAC_OPT_CK_LO]);
// both crystal codes have bit 4 set
assign clock_drive_out = opt_q[`DSAC_OPT_CK_HI];
assign supv_en         = !opt_q[`DSAC_OPT_SUPV];
assign g1_supv_pin     = supv_en;
assign portf_drv_en    = !opt_q[`DSAC_OPT_PORTF];
assign halt_allowed    = !opt_q[`DSAC_OPT_HALT];

// ----------------------------------------------------------------
// reset effects on the rest of the core
// ----------------------------------------------------------------
// every reset effect follows one registered level, so ports, control
// registers and the counter all leave reset on the same edge
assign in_reset     = warm_q;
assign ports_hiz    = warm_q;
assign port_d_high  = warm_q;
assign ctl_clear    = warm_q;
// only the R/C clock keeps accumulator and timers over warm reset
assign keep_acc_tmr = (clk_src == DSAC_CK_RC);

// ----------------------------------------------------------------
// program counter
// ----------------------------------------------------------------
logic [14:0] pc_q;
logic [7:0]  pm_q;

// reset outranks the interrupt vector, which outranks a jump and
// a plain step
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        pc_q <= `DSAC_PC_RST;
        pm_q <= `DSAC_UNPROG;
    end else if (clk_en) begin
        if (warm_q) begin
            pc_q <= `DSAC_PC_RST;
        end else if (irq_take) begin
            pc_q <= `DSAC_IRQ_VEC;
        end else if (pc_load) begin
            pc_q <= pc_load_val;
        end else if (pc_inc) begin
            pc_q <= pc_q + 15'h0001;
        end
        pm_q <= pmem_prog ? pmem_raw : `DSAC_UNPROG;
    end
end

assign prog_count_high = pc_q[14:8];
assign prog_count_low  = pc_q[7:0];
// fetch data is registered so it lines up with the counter edge
assign pmem_rdata      = pm_q;

// ----------------------------------------------------------------
// address formation and region decode
// ----------------------------------------------------------------
logic [7:0]    seg_q;
logic [7:0]    alt_q;
logic [7:0]    stk_q;
logic [7:0]    prim_q;
logic [15:0]   eff;
logic [7:0]    hi;
logic [7:0]    hi_m1;
logic [14:0]   ext_lin;
logic [EIW-1:0] ext_idx;
logic          ext_ok;
dsac_region_t  rg;

// stack and upper-half addresses skip extension
assign eff = (dstk || daddr[7]) ?
             {`DSAC_SEG_BASE, daddr} :
             {seg_q, 1'b0, daddr[6:0]};
// segment n lands on rows (n-1)*128 of ext_mem; ext_ok keeps an
// absent segment from ever using the index
assign hi      = eff[15:8];
assign hi_m1   = hi - 8'h01;
assign ext_lin = {hi_m1, eff[6:0]};
assign ext_idx = ext_lin[EIW-1:0];
assign ext_ok  = (hi != 8'h00) && ({24'h0, hi} <= NSEG);

always_comb begin
    rg = DSAC_RG_NONE;
    if (hi == 8'h00) begin
        if (!eff[7]) begin
            rg = (eff[6:0] <= `DSAC_RAM_TOP) ?
                 DSAC_RG_BASE : DSAC_RG_HOLE;
        end else if (eff[7:4] != `DSAC_REG_HI) begin
            rg = DSAC_RG_PERIPH;
        end else if (eff[3:0] <= `DSAC_GREG_TOP) begin
            rg = DSAC_RG_GREG;
        end else begin
            rg = DSAC_RG_PTR;
        end
    end else if (ext_ok) begin
        rg = DSAC_RG_EXT;
    end
end

assign periph_sel = (drd || dwr) && (rg == DSAC_RG_PERIPH);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
// RAM has no reset: contents are undefined at power-on and kept
// over a warm reset
logic [7:0] base_mem [0:111];
logic [7:0] greg_mem [0:11];
logic [7:0] ext_mem  [0:EXT_SEGS*128-1];
logic       we;

assign we = dwr && !warm_q;

always_ff @(posedge core_clk) begin
    if (clk_en && we) begin
        if (rg == DSAC_RG_BASE) begin
            base_mem[eff[6:0]] <= dwdata;
        end
        if (rg == DSAC_RG_GREG) begin
            greg_mem[eff[3:0]] <= dwdata;
        end
        if (rg == DSAC_RG_EXT) begin
            ext_mem[ext_idx] <= dwdata;
        end
    end
end

// ----------------------------------------------------------------
// memory-mapped pointers and segment register
// ----------------------------------------------------------------
logic ptr_we;
assign ptr_we = we && (rg == DSAC_RG_PTR);

logic alt_we;
logic stk_we;
logic prim_we;
logic seg_we;
assign alt_we  = ptr_we && (daddr == `DSAC_ADR_ALT);
assign stk_we  = ptr_we && (daddr == `DSAC_ADR_STK);
assign prim_we = ptr_we && (daddr == `DSAC_ADR_PRIM);
// a stack push that reaches 0FF must not move the segment window
assign seg_we  = ptr_we && !dstk && (daddr == `DSAC_ADR_SEG);

// alt and primary pointers survive a warm reset; only a cold reset sets them
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        alt_q  <= `DSAC_PTR_RST;
        prim_q <= `DSAC_PTR_RST;
    end else if (clk_en && ptr_we) begin
        if (alt_we) begin
            alt_q <= dwdata;
        end
        if (prim_we) begin
            prim_q <= dwdata;
        end
    end
end

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        stk_q <= `DSAC_STK_RST;
        seg_q <= `DSAC_SEG_RST;
    end else if (clk_en) begin
        if (warm_q) begin
            stk_q <= `DSAC_STK_RST;
            seg_q <= `DSAC_SEG_RST;
        end else if (ptr_we) begin
            if (stk_we) begin
                stk_q <= dwdata;
            end
            if (seg_we) begin
                seg_q <= dwdata;
            end
        end
    end
end

assign alt_ptr        = alt_q;
assign call_frame_top = stk_q;
assign prim_ptr       = prim_q;
assign window_bank    = seg_q;

// ----------------------------------------------------------------
// read path
// ----------------------------------------------------------------
logic [7:0]  ptr_rd;
logic [7:0]  rd_mux;
logic [7:0]  rd_q;
logic [15:0] ea_q;

always_comb begin
    unique case (daddr[1:0])
        2'h0:    ptr_rd = alt_q;
        2'h1:    ptr_rd = stk_q;
        2'h2:    ptr_rd = prim_q;
        2'h3:    ptr_rd = seg_q;
    endcase
end

// empty space reads as a fixed value rather than floating
always_comb begin
    unique case (rg)
        DSAC_RG_BASE:   rd_mux = base_mem[eff[6:0]];
        DSAC_RG_GREG:   rd_mux = greg_mem[eff[3:0]];
        DSAC_RG_PTR:    rd_mux = ptr_rd;
        DSAC_RG_PERIPH: rd_mux = periph_rdata;
        DSAC_RG_EXT:    rd_mux = ext_mem[ext_idx];
        default:        rd_mux = `DSAC_UNDEF_RD;
    endcase
end

// read data and formed address hold until the next access, so the
// core may take them in any cycle before it issues another
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        rd_q <= 8'h00;
        ea_q <= 16'h0000;
    end else if (clk_en && (drd || dwr)) begin
        ea_q <= eff;
        if (drd) begin
            rd_q <= rd_mux;
        end
    end
end

assign drdata    = rd_q;
assign deff_addr = ea_q;

endmodule // dsac_top

// ===== tb/dsac_top_chk.sv
`timescale 1ns/1ps
module dsac_top_chk
    import dsac_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic [7:0]  opt_word,
    input wire logic [7:0]  daddr,
    input wire logic        drd,
    input wire logic        dwr,
    input wire logic        dstk,
    input wire logic        irq_take,
    input wire logic        pmem_prog,
    input wire logic [7:0]  pmem_raw,
    input wire logic [15:0] deff_addr,
    input wire logic        periph_sel,
    input wire logic [6:0]  prog_count_high,
    input wire logic [7:0]  prog_count_low,
    input wire logic [7:0]  pmem_rdata,
    input wire logic [7:0]  call_frame_top,
    input wire logic [7:0]  window_bank,
    input wire logic        por_en,
    input wire logic        secure_en,
    input dsac_clk_src_t    clk_src,
    input wire logic        supv_en,
    input wire logic        portf_drv_en,
    input wire logic        halt_allowed,
    input wire logic        in_reset,
    input wire logic        ports_hiz,
    input wire logic        port_d_high,
    input wire logic        ctl_clear
);
    wire [14:0] pc  = {prog_count_high, prog_count_low};
    wire        go  = clk_en && !in_reset;
    wire        acc = go && (drd || dwr);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_pc_reset: assert property (in_reset && clk_en |=> pc == 15'h0)
        else $error("counter not cleared in reset");
    a_irq_vec: assert property (go && irq_take |=> pc == 15'h00FF)
        else $error("interrupt did not vector to 0FF");
    a_pmem_blank: assert property (
        go && !pmem_prog |=> pmem_rdata == 8'h00)
        else $error("blank program byte not 00");
    a_pmem_pass: assert property (
        go && pmem_prog |=> pmem_rdata == $past(pmem_raw))
        else $error("programmed byte not passed");
    a_base_addr: assert property (
        acc && (daddr[7] || dstk) |=> deff_addr == {8'h00, $past(daddr)})
        else $error("base address formed wrongly");
    a_seg_addr: assert property (
        acc && !daddr[7] && !dstk
        |=> deff_addr == {$past(window_bank), $past(daddr) & 8'h7F})
        else $error("segment address formed wrongly");
    a_stack_seg: assert property (
        acc && dstk |=> $stable(window_bank))
        else $error("stack access changed segment");
    a_periph_sel: assert property (!in_reset |-> periph_sel ==
        ((drd || dwr) && daddr >= 8'h80 && daddr <= 8'hEF))
        else $error("peripheral select wrong");
    a_sp_init: assert property (in_reset && clk_en
        |=> call_frame_top == 8'h6F && window_bank == 8'h00)
        else $error("stack pointer or segment not reset");
    a_opt_fields: assert property (!in_reset |->
        {por_en, secure_en, clk_src, supv_en, portf_drv_en, halt_allowed}
        == {opt_word[6:3], ~opt_word[2:0]})
        else $error("option decode wrong");
    a_rst_ports: assert property (
        {ports_hiz, port_d_high, ctl_clear} == {3{in_reset}})
        else $error("reset port state wrong");
endmodule // dsac_top_chk

bind dsac_top dsac_top_chk u_chk (.core_clk, .arst_n, .clk_en, .opt_word,
    .daddr, .drd, .dwr, .dstk, .irq_take, .pmem_prog, .pmem_raw, .deff_addr,
    .periph_sel, .prog_count_high, .prog_count_low, .pmem_rdata,
    .call_frame_top, .window_bank, .por_en, .secure_en, .clk_src, .supv_en,
    .portf_drv_en, .halt_allowed, .in_reset, .ports_hiz, .port_d_high,
    .ctl_clear);

// ===== tb/dsac_cpu_bfm.sv
`timescale 1ns/1ps
module dsac_cpu_bfm (
    input  wire logic       core_clk,     // core clock
    output logic      [7:0] daddr,        // single-byte address
    output logic            drd,          // read strobe
    output logic            dwr,          // write strobe
    output logic            dstk,         // access via stack pointer
    output logic      [7:0] dwdata,       // write data
    output logic      [7:0] periph_rdata  // peripheral answer
);
    initial begin
        {daddr, drd, dwr, dstk, dwdata, periph_rdata} = '0;
    end
    // address and write data are inverted after the taken edge so a stale value never
    // passes for a live one
    task automatic acc(input logic w, input logic s, input logic [7:0] a,
                       input logic [7:0] d);
        repeat ($urandom % 2) @(posedge core_clk);
        @(posedge core_clk);
        daddr        <= a;
        dstk         <= s;
        dwdata       <= d;
        drd          <= !w;
        dwr          <= w;
        periph_rdata <= 8'($urandom);
        @(posedge core_clk);
        drd    <= 1'b0;
        dwr    <= 1'b0;
        daddr  <= ~a;
        dwdata <= ~d;
    endtask
endmodule // dsac_cpu_bfm

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    import dsac_pkg::*;
    logic          core_clk = 1'b0;
    logic          arst_n = 1'b0;
    logic          clk_en = 1'b1;
    logic          reset_pin_n = 1'b1;
    logic [7:0]    opt_word = 8'h00;
    logic          pc_load = 1'b0;
    logic [14:0]   pc_load_val = 15'h0;
    logic          pc_inc = 1'b0;
    logic          irq_take = 1'b0;
    logic          por_req = 1'b0;
    logic [7:0]    pmem_raw = 8'h00;
    logic          pmem_prog = 1'b0;
    wire  [7:0]    daddr, dwdata, periph_rdata, drdata, prog_count_low;
    wire  [7:0]    alt_ptr, call_frame_top, prim_ptr, window_bank;
    wire           drd, dwr, dstk, por_en, secure_en, clock_drive_out;
    wire           supv_en, g1_supv_pin, portf_drv_en, halt_allowed;
    wire           in_reset, keep_acc_tmr, ports_hiz, port_d_high, ctl_clear;
    wire  [6:0]    prog_count_high;
    wire  [15:0]   deff_addr;
    dsac_clk_src_t clk_src;
    logic [7:0]    m [int];
    logic [7:0]    wq [$];
    int            pcm;
    int            n_fail = 0;
    int            check_count = 0;
    wire  [9:0]    opt_seen = {por_en, secure_en, clk_src, clock_drive_out,
        supv_en, g1_supv_pin, portf_drv_en, halt_allowed, keep_acc_tmr};
    wire  [2:0]    rst_out = {ports_hiz, port_d_high, ctl_clear};
    wire  [7:0]    drdata_mr;
    dsac_cpu_bfm cpu (.core_clk, .daddr, .drd, .dwr, .dstk, .dwdata,
        .periph_rdata);
    dsac_top #(.EXT_SEGS(3), .MASK_ROM(1'b0)) dut (.core_clk, .arst_n,
        .clk_en, .reset_pin_n, .por_req, .opt_word, .daddr, .drd,
        .dwr, .dstk, .dwdata, .drdata, .deff_addr, .periph_sel(),
        .periph_rdata, .pc_load, .pc_load_val, .pc_inc, .irq_take,
        .prog_count_high, .prog_count_low, .pmem_raw, .pmem_prog,
        .pmem_rdata(), .alt_ptr, .call_frame_top, .prim_ptr, .window_bank,
        .por_en, .secure_en, .clk_src, .clock_drive_out, .supv_en,
        .g1_supv_pin, .portf_drv_en, .halt_allowed, .in_reset,
        .ports_hiz, .port_d_high, .ctl_clear, .keep_acc_tmr);
    dsac_top #(.EXT_SEGS(3), .MASK_ROM(1'b1)) dut_mr (.core_clk, .arst_n,
        .clk_en, .reset_pin_n, .por_req, .opt_word, .daddr, .drd, .dwr,
        .dstk, .dwdata, .drdata(drdata_mr), .deff_addr(), .periph_sel(),
        .periph_rdata, .pc_load, .pc_load_val, .pc_inc, .irq_take,
        .prog_count_high(), .prog_count_low(), .pmem_raw, .pmem_prog,
        .pmem_rdata(), .alt_ptr(), .call_frame_top(), .prim_ptr(),
        .window_bank(), .por_en(), .secure_en(), .clk_src(),
        .clock_drive_out(), .supv_en(), .g1_supv_pin(), .portf_drv_en(),
        .halt_allowed(), .in_reset(), .ports_hiz(), .port_d_high(),
        .ctl_clear(), .keep_acc_tmr());
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        pmem_raw  <= 8'($urandom);
        pmem_prog <= 1'($urandom);
    end
    task automatic summarize;
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic ck(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic ck_state;
        ck("regs", {m[252], m[253], m[254], m[255]},
           {alt_ptr, call_frame_top, prim_ptr, window_bank});
        ck("pc", pcm, {prog_count_high, prog_count_low});
    endtask
    task automatic wait_rst(input logic lvl);
        for (int i = 0; i < 40 && in_reset !== lvl; i++) @(negedge core_clk);
        ck("in_reset", lvl, in_reset);
        if (in_reset !== lvl) summarize();
    endtask
    task automatic cold(input logic [7:0] o);
        @(posedge core_clk);
        arst_n   <= 1'b0;
        opt_word <= o;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        wait_rst(1'b0);
        m.delete();
        m[252] = 8'h00;
        m[253] = 8'h6F;
        m[254] = 8'h00;
        m[255] = 8'h00;
        pcm = 0;
        ck_state();
        ck("opt", {o[6:3], o[4], ~o[2], ~o[2], ~o[1:0], o[4:3] == 2'h1},
           opt_seen);
    endtask
    task automatic op(input logic w, input logic s, input logic [7:0] a,
                      input logic [7:0] d);
        int         e;
        logic [7:0] x;
        e = (s || a[7]) ? int'(a) : m[255] * 256 + a[6:0];
        cpu.acc(w, s, a, d);
        @(negedge core_clk);
        ck("addr", e, deff_addr);
        if (w && !(s && e == 'hFF) && (e < 'h70 || (e >= 'hF0 && e < 'h400)))
            m[e] = d;
        if (!w && (!(e < 'h70 || (e >= 'hF0 && e < 'h400)) || m.exists(e)))
        begin
            x = (e >= 'h80 && e < 'hF0) ? periph_rdata :
                m.exists(e) ? m[e] : 8'h00;
            ck("data", x, drdata);
        end
        if (!w && e >= 'h200 && e < 'h400)
            ck("mr data", 8'h00, drdata_mr);
        ck_state();
    endtask
    task automatic pcop(input logic ld, input logic [14:0] v,
                        input logic inc, input logic irq, input logic en);
        @(posedge core_clk);
        pc_load     <= ld;
        pc_load_val <= v;
        pc_inc      <= inc;
        irq_take    <= irq;
        clk_en      <= en;
        @(posedge core_clk);
        pc_load  <= 1'b0;
        pc_inc   <= 1'b0;
        irq_take <= 1'b0;
        clk_en   <= 1'b1;
        if (en) pcm = irq ? 'hFF : ld ? int'(v) : (pcm + inc) % 'h8000;
        @(negedge core_clk);
        ck("pc", pcm, {prog_count_high, prog_count_low});
    endtask
    initial begin
        logic       w;
        logic [7:0] a;
        void'($urandom(32'hCDAB));
        for (int i = 0; i < 4; i++) cold(8'($urandom) & 8'hE7 | 8'(i << 3));
        for (int i = 0; i < 400; i++) begin
            w = 1'($urandom);
            a = 8'($urandom);
            if (!w && wq.size() > 0 && $urandom % 2)
                a = wq[$urandom % wq.size()];
            if (w) wq.push_back(a);
            op(w, $urandom % 4 == 0, a,
               a == 8'hFF ? 8'($urandom % 5) : 8'($urandom));
        end
        op(1'b1, 1'b0, 8'hFC, 8'h3C);
        op(1'b1, 1'b0, 8'hFE, 8'hC3);
        op(1'b1, 1'b0, 8'hFD, 8'h21);
        op(1'b1, 1'b0, 8'hFF, 8'h02);
        op(1'b1, 1'b1, 8'hFF, 8'h01);
        op(1'b1, 1'b0, 8'h10, 8'h99);
        pcop(1'b1, 15'h7FFF, 1'b0, 1'b0, 1'b1);
        pcop(1'b0, 15'h0, 1'b1, 1'b0, 1'b1);
        @(posedge core_clk);
        reset_pin_n <= 1'b0;
        wait_rst(1'b1);
        ck("rst_out", 3'h7, rst_out);
        // this write lands while reset is active and must be dropped
        cpu.acc(1'b1, 1'b0, 8'hFC, 8'h00);
        @(posedge core_clk);
        reset_pin_n <= 1'b1;
        wait_rst(1'b0);
        m[253] = 8'h6F;
        m[255] = 8'h00;
        pcm = 0;
        ck_state();
        ck("rst_out", 3'h0, rst_out);
        op(1'b1, 1'b0, 8'hFF, 8'h02);
        op(1'b0, 1'b0, 8'h10, 8'h00);
        for (int i = 0; i < 60; i++)
            pcop($urandom % 4 == 0, 15'($urandom), 1'($urandom),
                 $urandom % 8 == 0, $urandom % 6 != 0);
        @(posedge core_clk);
        por_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        ck("por", opt_word[6], in_reset);
        @(posedge core_clk);
        por_req <= 1'b0;
        wait_rst(1'b0);
        summarize();
    end
endmodule // tb
